/* File: common/odu_mux_defs.svh */
/*
 * constants of the tributary multiplexer: widths, table depth, payload
 * type codes, tributary unit sizes, client limits and alignment word.
 * assumes inclusion by bare name from the package file.
 */
`ifndef ODU_MUX_DEFS_SVH
`define ODU_MUX_DEFS_SVH

// ----------------------------------------------------------------------------
// widths and depth
// ----------------------------------------------------------------------------
`define TRIB_DEPTH     80
`define TRIB_LAST      7'h4f
`define TRIB_IDX_W     7
`define DATA_W         32
`define TS_W           8
`define CNT_W          8
`define CN_N_W         4
`define MF_W           3

// ----------------------------------------------------------------------------
// group coding and alignment
// ----------------------------------------------------------------------------
`define PT_OPUK        8'h15
`define PT_OPUCN       8'h16
`define FAS_WORD       32'ha5a5_5a5a
`define CN_MULT        8'h0a

// ----------------------------------------------------------------------------
// tributary unit sizes in slots
// ----------------------------------------------------------------------------
`define TS_K_ODU0      8'h01
`define TS_K_ODU1      8'h02
`define TS_K_ODU2      8'h08
`define TS_K_ODU3      8'h1f
`define TS_C_ODU0      8'h01
`define TS_C_ODU1      8'h01
`define TS_C_ODU2      8'h02
`define TS_C_ODU3      8'h08
`define TS_C_ODU4      8'h14

// ----------------------------------------------------------------------------
// client limits per payload
// ----------------------------------------------------------------------------
`define LIM4_ODU0      8'h50
`define LIM4_ODU1      8'h28
`define LIM4_ODU2      8'h0a
`define LIM4_ODU3      8'h02
`define LIM25_ODU0     8'h14
`define LIM25_ODU1     8'h0a
`define LIM25_ODU2     8'h02
`define LIM50_ODU0     8'h28
`define LIM50_ODU1     8'h14
`define LIM50_ODU2     8'h05
`define LIM50_ODU3     8'h01

`endif

/* File: common/odu_mux_pkg.sv */
/*
 * types of the tributary multiplexer: client kinds, payload modes,
 * controller states, table entry and controller state record.
 * assumes odu_mux_defs.svh is on the include path.
 */
`include "odu_mux_defs.svh"

package odu_mux_pkg;

   typedef enum logic [2:0] {
      CL_NONE  = 3'b000,
      CL_ODU0  = 3'b001,
      CL_ODU1  = 3'b010,
      CL_ODU2  = 3'b011,
      CL_ODU2E = 3'b100,
      CL_ODU3  = 3'b101,
      CL_ODU4  = 3'b110,
      CL_FLEX  = 3'b111
   } client_e;

   typedef enum logic [1:0] {
      HOP_OPU4  = 2'b00,
      HOP_OPU25 = 2'b01,
      HOP_OPU50 = 2'b10,
      HOP_OPUCN = 2'b11
   } hop_e;

   typedef enum logic [1:0] {
      ST_IDLE  = 2'b00,
      ST_SCAN  = 2'b01,
      ST_RUN   = 2'b10,
      ST_FAULT = 2'b11
   } mux_state_e;

   typedef struct packed {
      client_e           kind;
      logic [`TS_W-1:0]  ts;
   } trib_ent_s;

   typedef struct packed {
      mux_state_e                   st;
      logic                         busy;
      logic                         check;
      logic [`TRIB_IDX_W-1:0]       ent;
      logic [`TS_W-1:0]             rep;
      logic [`MF_W-1:0]             mf;
      hop_e                         hop;
      logic [`CN_N_W-1:0]           n;
      logic [7:0][`CNT_W-1:0]       cnt;
      logic                         bad_ts;
      logic                         ok;
      logic                         err;
      logic                         gsof;
      logic                         cli_rdy;
      logic [`TRIB_IDX_W-1:0]       slot;
      logic                         wr_refused;
   } mux_st_s;

endpackage

/* File: design/odu_skid_buffer.sv */
/*
 * two-entry buffer between the slot sequencer and the group output.
 * assumes the writer pushes only while in_ready_out is high.
 */
module odu_skid_buffer
   import odu_mux_pkg::*;
#(
   parameter int W = 58
)
(
   input  wire logic          clk_sys_in,
   input  wire logic          sys_rst_in,
   input  wire logic          in_valid_in,
   input  wire logic [W-1:0]  in_data_in,
   output logic               in_ready_out,
   output logic               in_ready_next_out,
   output logic               out_valid_out,
   output logic [W-1:0]       out_data_out,
   input  wire logic          out_ready_in
);

   typedef struct packed {
      logic [W-1:0] head;
      logic         head_v;
      logic [W-1:0] skid;
      logic         skid_v;
   } buf_st_s;

   buf_st_s s_q;
   buf_st_s s_d;

   // ----------------------------------------------------------------------------
   // pop, refill from skid, then push
   // ----------------------------------------------------------------------------
   always_comb
   begin
      s_d = s_q;
      if (s_q.head_v && out_ready_in)
      begin
         s_d.head_v = 1'b0;
      end
      if (!s_d.head_v && s_q.skid_v)
      begin
         s_d.head   = s_q.skid;
         s_d.head_v = 1'b1;
         s_d.skid_v = 1'b0;
      end
      if (in_valid_in)
      begin
         if (!s_d.head_v)
         begin
            s_d.head   = in_data_in;
            s_d.head_v = 1'b1;
         end
         else
         begin
            s_d.skid   = in_data_in;
            s_d.skid_v = 1'b1;
         end
      end
   end

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q <= s_d;
      end
   end

   assign in_ready_out      = !s_q.skid_v;
   assign in_ready_next_out = !s_d.skid_v;
   assign out_valid_out     = s_q.head_v;
   assign out_data_out      = s_q.head;

endmodule

/* File: design/odu_limit_check.sv */
/*
 * judges the per-type client counts of a tributary table against the
 * limits of the selected higher-order payload.
 * assumes counts are stable while the result is sampled.
 */
module odu_limit_check
   import odu_mux_pkg::*;
(
   input  wire hop_e                      hop_in,
   input  wire logic [`CN_N_W-1:0]        n_in,
   input  wire logic [7:0][`CNT_W-1:0]    cnt_in,
   input  wire logic                      bad_ts_in,
   output logic                           ok_out
);

   logic [`CNT_W-1:0] ten_n;
   logic [7:0]        over;
   logic [`CNT_W:0]   sum_one;
   logic [`CNT_W:0]   sum_two;
   logic [`CNT_W+2:0] sum_all;
   logic              cn_bad;

   assign ten_n = `CNT_W'({4'h0, n_in} * `CN_MULT);

   function automatic logic [`CNT_W-1:0] lim(input hop_e h, input int t,
                                               input logic [`CNT_W-1:0] tn,
                                               input logic [`CN_N_W-1:0] nn);
      logic [`CNT_W-1:0] r;
      r = 8'h00;
      case (h)
         HOP_OPU4:
         begin
            case (t)
               1, 7:    r = `LIM4_ODU0;
               2:       r = `LIM4_ODU1;
               3, 4:    r = `LIM4_ODU2;
               5:       r = `LIM4_ODU3;
               default: r = 8'h00;
            endcase
         end
         HOP_OPU25:
         begin
            case (t)
               1, 7:    r = `LIM25_ODU0;
               2:       r = `LIM25_ODU1;
               3, 4:    r = `LIM25_ODU2;
               default: r = 8'h00;
            endcase
         end
         HOP_OPU50:
         begin
            case (t)
               1, 7:    r = `LIM50_ODU0;
               2:       r = `LIM50_ODU1;
               3, 4:    r = `LIM50_ODU2;
               5:       r = `LIM50_ODU3;
               default: r = 8'h00;
            endcase
         end
         HOP_OPUCN:
         begin
            case (t)
               5:       r = {2'b00, tn[`CNT_W-1:2]};
               6:       r = {4'h0, nn};
               default: r = tn;
            endcase
         end
         default: r = 8'h00;
      endcase
      return r;
   endfunction

   // ----------------------------------------------------------------------------
   // per-type limit compare
   // ----------------------------------------------------------------------------
   assign over[0] = 1'b0;
   for (genvar t = 1; t < 8; t++)
   begin : g_type
      assign over[t] = cnt_in[t] > lim(hop_in, t, ten_n, n_in);
   end

   // ----------------------------------------------------------------------------
   // unit-size sums for the beyond-100G payload
   // ----------------------------------------------------------------------------
   always_comb
   begin
      sum_one = {1'b0, cnt_in[1]} + {1'b0, cnt_in[2]};
      sum_two = {1'b0, cnt_in[3]} + {1'b0, cnt_in[4]};
      sum_all = {2'b00, sum_one} + {2'b00, sum_two} + {3'b000, cnt_in[5]}
              + {3'b000, cnt_in[6]} + {3'b000, cnt_in[7]};
      cn_bad  = (hop_in == HOP_OPUCN) &&
                ((n_in == 4'h0) || (sum_one > {1'b0, ten_n}) ||
                 (sum_two > {1'b0, ten_n}) || (sum_all > {3'b000, ten_n}));
      ok_out  = !(|over) && !bad_ts_in && !cn_bad;
   end

endmodule

/* File: design/odu_tributary_multiplexer.sv */
/*
 * tributary multiplexer: holds a table of client tributaries, checks it
 * against the payload limits, then walks the table slot by slot, inserts
 * frame alignment words, takes client words or justification stuff and
 * hands the group words to a two-entry buffer toward the framer.
 * assumes client and framer logic run on clk_sys_in.
 */
module odu_tributary_multiplexer
   import odu_mux_pkg::*;
(
   input  wire logic                       clk_sys_in,
   input  wire logic                       sys_rst_in,
   input  wire logic                       cfg_wr_in,
   input  wire logic [`TRIB_IDX_W-1:0]     cfg_idx_in,
   input  wire logic [2:0]                 cfg_kind_in,
   input  wire logic [`TS_W-1:0]           cfg_ts_in,
   input  wire logic [1:0]                 cfg_hop_in,
   input  wire logic [`CN_N_W-1:0]         cfg_n_in,
   input  wire logic                       cfg_apply_in,
   input  wire logic                       cfg_stop_in,
   output logic                            cfg_busy_out,
   output logic                            cfg_ok_out,
   output logic                            cfg_err_out,
   output logic                            cfg_wr_refused_out,
   output logic                            cli_ready_out,
   output logic [`TRIB_IDX_W-1:0]          slot_trib_out,
   input  wire logic                       cli_valid_in,
   input  wire logic [`TRIB_IDX_W-1:0]     cli_idx_in,
   input  wire logic [`DATA_W-1:0]         cli_data_in,
   output logic                            out_valid_out,
   input  wire logic                       out_ready_in,
   output logic [`DATA_W-1:0]              out_data_out,
   output logic [`TRIB_IDX_W-1:0]          out_trib_out,
   output logic [`TS_W-1:0]                out_tu_ts_out,
   output logic [7:0]                      out_pt_out,
   output logic                            out_stuff_out,
   output logic                            out_fas_out,
   output logic                            out_gsof_out
);

   localparam int WORD_W = `DATA_W + `TRIB_IDX_W + `TS_W + 8 + 3;

   mux_st_s              s_q;
   mux_st_s              s_d;
   trib_ent_s            tab_q [`TRIB_DEPTH];
   trib_ent_s            ent_cur;
   trib_ent_s            ent_nxt;
   logic [`TS_W-1:0]     ts_cur;
   logic                 chk_ok;
   logic                 push;
   logic                 take;
   logic                 fas_now;
   logic [WORD_W-1:0]    word;
   logic [WORD_W-1:0]    word_out;
   logic                 buf_ready;
   logic                 buf_ready_next;
   logic                 tab_open;

   // ----------------------------------------------------------------------------
   // tributary unit size of one table entry
   // ----------------------------------------------------------------------------
   function automatic logic [`TS_W-1:0] tu_slots(input hop_e h, input trib_ent_s e);
      logic [`TS_W-1:0] r;
      r = 8'h00;
      if (h == HOP_OPUCN)
      begin
         case (e.kind)
            CL_ODU0:           r = `TS_C_ODU0;
            CL_ODU1:           r = `TS_C_ODU1;
            CL_ODU2, CL_ODU2E: r = `TS_C_ODU2;
            CL_ODU3:           r = `TS_C_ODU3;
            CL_ODU4:           r = `TS_C_ODU4;
            CL_FLEX:           r = e.ts;
            default:           r = 8'h00;
         endcase
      end
      else
      begin
         case (e.kind)
            CL_ODU0:           r = `TS_K_ODU0;
            CL_ODU1:           r = `TS_K_ODU1;
            CL_ODU2, CL_ODU2E: r = `TS_K_ODU2;
            CL_ODU3:           r = `TS_K_ODU3;
            CL_FLEX:           r = e.ts;
            default:           r = 8'h00;
         endcase
      end
      return r;
   endfunction

   // ----------------------------------------------------------------------------
   // submodules
   // ----------------------------------------------------------------------------
   odu_limit_check u_check
   (
      .hop_in    (s_q.hop),
      .n_in      (s_q.n),
      .cnt_in    (s_q.cnt),
      .bad_ts_in (s_q.bad_ts),
      .ok_out    (chk_ok)
   );

   odu_skid_buffer #(
      .W (WORD_W)
   ) u_buf
   (
      .clk_sys_in        (clk_sys_in),
      .sys_rst_in        (sys_rst_in),
      .in_valid_in       (push),
      .in_data_in        (word),
      .in_ready_out      (buf_ready),
      .in_ready_next_out (buf_ready_next),
      .out_valid_out     (out_valid_out),
      .out_data_out      (word_out),
      .out_ready_in      (out_ready_in)
   );

   // ----------------------------------------------------------------------------
   // current slot word
   // ----------------------------------------------------------------------------
   assign ent_cur = tab_q[s_q.ent];
   assign ts_cur  = tu_slots(s_q.hop, ent_cur);
   assign fas_now = (s_q.rep == 8'h00) && (s_q.mf == 3'h0);
   assign take    = s_q.cli_rdy && cli_valid_in && (cli_idx_in == s_q.ent);
   assign push    = (s_q.st == ST_RUN) && !cfg_stop_in && buf_ready
                    && (ent_cur.kind != CL_NONE);

   always_comb
   begin
      word = '0;
      word[`DATA_W-1:0] = fas_now ? `FAS_WORD :
                          (take ? cli_data_in : 32'h0000_0000);
      word[`DATA_W +: `TRIB_IDX_W] = s_q.ent;
      word[`DATA_W + `TRIB_IDX_W +: `TS_W] = ts_cur;
      word[`DATA_W + `TRIB_IDX_W + `TS_W +: 8] =
         (s_q.hop == HOP_OPUCN) ? `PT_OPUCN : `PT_OPUK;
      word[WORD_W-3] = !fas_now && !take;   // gmp justification stuff
      word[WORD_W-2] = fas_now;
      word[WORD_W-1] = s_q.gsof;
   end

   // ----------------------------------------------------------------------------
   // controller
   // ----------------------------------------------------------------------------
   assign tab_open = (s_q.st == ST_IDLE) || (s_q.st == ST_FAULT);

   always_comb
   begin
      s_d = s_q;
      s_d.cli_rdy    = 1'b0;
      s_d.wr_refused = cfg_wr_in && !tab_open;
      case (s_q.st)
         ST_IDLE, ST_FAULT:
         begin
            if (cfg_apply_in)
            begin
               s_d.st     = ST_SCAN;
               s_d.busy   = 1'b1;
               s_d.check  = 1'b0;
               s_d.ent    = '0;
               s_d.cnt    = '0;
               s_d.bad_ts = 1'b0;
               s_d.hop    = hop_e'(cfg_hop_in);
               s_d.n      = cfg_n_in;
               s_d.ok     = 1'b0;
               s_d.err    = 1'b0;
            end
         end
         ST_SCAN:
         begin
            if (s_q.check)
            begin
               s_d.check = 1'b0;
               s_d.ent   = '0;
               s_d.rep   = '0;
               s_d.mf    = '0;
               s_d.gsof  = 1'b1;
               s_d.busy  = 1'b0;
               if (chk_ok)
               begin
                  s_d.st = ST_RUN;
                  s_d.ok = 1'b1;
               end
               else
               begin
                  s_d.st  = ST_FAULT;
                  s_d.err = 1'b1;
               end
            end
            else
            begin
               if (ent_cur.kind != CL_NONE)
               begin
                  s_d.cnt[ent_cur.kind] = s_q.cnt[ent_cur.kind] + 8'h01;
               end
               if ((ent_cur.kind == CL_FLEX) && (ent_cur.ts == 8'h00))
               begin
                  s_d.bad_ts = 1'b1;
               end
               if (s_q.ent == `TRIB_LAST)
               begin
                  s_d.check = 1'b1;
               end
               else
               begin
                  s_d.ent = s_q.ent + 7'h01;
               end
            end
         end
         ST_RUN:
         begin
            if (cfg_stop_in)
            begin
               s_d.st = ST_IDLE;
               s_d.ok = 1'b0;
            end
            else if (buf_ready)
            begin
               if (push)
               begin
                  s_d.gsof = 1'b0;
               end
               if ((ent_cur.kind != CL_NONE) && (s_q.rep + 8'h01 < ts_cur))
               begin
                  s_d.rep = s_q.rep + 8'h01;
               end
               else
               begin
                  s_d.rep = '0;
                  if (s_q.ent == `TRIB_LAST)
                  begin
                     s_d.ent  = '0;
                     s_d.mf   = s_q.mf + 3'h1;
                     s_d.gsof = 1'b1;
                  end
                  else
                  begin
                     s_d.ent = s_q.ent + 7'h01;
                  end
               end
            end
         end
         default:
         begin
            s_d.st = ST_IDLE;
         end
      endcase
      s_d.slot = s_d.ent;
   end

   // offer the next slot to clients only when it will really execute, unless cfg_stop_in is high in that cycle
   assign ent_nxt = tab_q[s_d.ent];

   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         s_q <= '0;
      end
      else
      begin
         s_q         <= s_d;
         s_q.cli_rdy <= (s_d.st == ST_RUN) && buf_ready_next && (ent_nxt.kind != CL_NONE)
                        && !((s_d.rep == 8'h00) && (s_d.mf == 3'h0));
      end
   end

   // ----------------------------------------------------------------------------
   // tributary table
   // ----------------------------------------------------------------------------
   always_ff @(posedge clk_sys_in)
   begin
      if (sys_rst_in)
      begin
         for (int i = 0; i < `TRIB_DEPTH; i++)
         begin
            tab_q[i] <= '0;
         end
      end
      else if (cfg_wr_in && tab_open && (cfg_idx_in <= `TRIB_LAST))
      begin
         tab_q[cfg_idx_in] <= '{kind: client_e'(cfg_kind_in), ts: cfg_ts_in};
      end
   end

   // ----------------------------------------------------------------------------
   // outputs
   // ----------------------------------------------------------------------------
   assign cfg_busy_out       = s_q.busy;
   assign cfg_ok_out         = s_q.ok;
   assign cfg_err_out        = s_q.err;
   assign cfg_wr_refused_out = s_q.wr_refused;
   assign cli_ready_out      = s_q.cli_rdy;
   assign slot_trib_out      = s_q.slot;
   assign out_data_out       = word_out[`DATA_W-1:0];
   assign out_trib_out       = word_out[`DATA_W +: `TRIB_IDX_W];
   assign out_tu_ts_out      = word_out[`DATA_W + `TRIB_IDX_W +: `TS_W];
   assign out_pt_out         = word_out[`DATA_W + `TRIB_IDX_W + `TS_W +: 8];
   assign out_stuff_out      = word_out[WORD_W-3];
   assign out_fas_out        = word_out[WORD_W-2];
   assign out_gsof_out       = word_out[WORD_W-1];

endmodule

/* File: dv/odu_mux_sva.sv */
/* port checker of the tributary multiplexer.
   assumes a bind onto odu_tributary_multiplexer. */
module odu_mux_sva
   import odu_mux_pkg::*;
(
   input wire logic        clk_sys_in,
   input wire logic        sys_rst_in,
   input wire logic        cfg_wr_in,
   input wire logic        cfg_apply_in,
   input wire logic        cfg_stop_in,
   input wire logic        cfg_busy_out,
   input wire logic        cfg_ok_out,
   input wire logic        cfg_err_out,
   input wire logic        cfg_wr_refused_out,
   input wire logic        out_valid_out,
   input wire logic        out_ready_in,
   input wire logic [31:0] out_data_out,
   input wire logic [7:0]  out_pt_out,
   input wire logic        out_stuff_out,
   input wire logic        out_fas_out
);
   wire idle_w = !cfg_busy_out && !cfg_ok_out;
   default clocking dc @(posedge clk_sys_in);
   endclocking
   default disable iff (sys_rst_in);
   AST_BUSY_LEN: assert property ($rose(cfg_busy_out) |-> ##80 cfg_busy_out
      ##1 !cfg_busy_out && (cfg_ok_out ^ cfg_err_out)) else $error("check length wrong");
   AST_APPLY: assert property (cfg_apply_in && idle_w |=> cfg_busy_out)
      else $error("apply not taken");
   AST_REFUSE: assert property (cfg_wr_in && !idle_w |=> cfg_wr_refused_out)
      else $error("write not refused");
   AST_NO_REFUSE: assert property (idle_w |=> !cfg_wr_refused_out)
      else $error("false refusal");
   AST_STOP: assert property (cfg_ok_out && cfg_stop_in |=> !cfg_ok_out)
      else $error("stop ignored");
   AST_HOLD: assert property (out_valid_out && !out_ready_in |=>
      out_valid_out && $stable(out_data_out)) else $error("word lost in stall");
   AST_FAS: assert property (out_valid_out && out_fas_out |->
      out_data_out == 32'ha5a5_5a5a && !out_stuff_out) else $error("bad alignment word");
   AST_STUFF: assert property (out_valid_out && out_stuff_out |->
      out_data_out == 32'h0) else $error("stuff not zero");
   AST_PT: assert property (out_valid_out |-> out_pt_out inside {8'h15, 8'h16})
      else $error("bad payload type");
   cover property ($rose(cfg_ok_out));
   cover property ($rose(cfg_err_out));
   cover property (out_valid_out && out_fas_out);
endmodule

bind odu_tributary_multiplexer odu_mux_sva chk_u (.*);

/* File: dv/odu_framer_model.sv */
/* framer model: takes group words with a stall pattern and keeps them.
   assumes the multiplexer clock. */
module odu_framer_model
(
   input  wire logic        clk_sys_in,
   input  wire logic        valid_in,
   input  wire logic [57:0] word_in,
   output logic             ready_out
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [2:0]  ph_q = 3'h0;
   logic [57:0] words_q[$];
   always @(negedge clk_sys_in)
   begin
      ph_q <= ph_q + 3'h1;
      ready_out <= ph_q[1];
   end
   always @(posedge clk_sys_in)
   begin
      if (valid_in && ready_out)
         words_q.push_back(word_in);
   end
endmodule

/* File: dv/odu_tributary_multiplexer_tb_top.sv */
/* testbench of the tributary multiplexer: limit table and running group.
   assumes framer model and checker compiled alongside. */
module odu_tributary_multiplexer_tb_top
   import odu_mux_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk_sys_in = 1'b0;
   logic        sys_rst_in = 1'b1;
   logic        cfg_wr_in = 1'b0;
   logic [6:0]  cfg_idx_in = 7'h00;
   logic [2:0]  cfg_kind_in = 3'h0;
   logic [7:0]  cfg_ts_in = 8'h05;
   logic [1:0]  cfg_hop_in = 2'h0;
   logic [3:0]  cfg_n_in = 4'h0;
   logic        cfg_apply_in = 1'b0;
   logic        cfg_stop_in = 1'b0;
   logic        cli_valid_in = 1'b0;
   logic [6:0]  cli_idx_in = 7'h00;
   logic [31:0] cli_data_in = 32'h1234_5678;
   wire logic   out_ready_in;
   wire logic   cfg_busy_out, cfg_ok_out, cfg_err_out, cfg_wr_refused_out, cli_ready_out;
   wire logic   out_valid_out, out_stuff_out, out_fas_out, out_gsof_out;
   wire logic [6:0]  slot_trib_out, out_trib_out;
   wire logic [31:0] out_data_out;
   wire logic [7:0]  out_tu_ts_out, out_pt_out;
   int          mismatches = 0;
   int          checks_done = 0;

   odu_tributary_multiplexer dut_u (.*);
   odu_framer_model fw_u (.clk_sys_in(clk_sys_in), .valid_in(out_valid_out),
      .word_in({out_gsof_out, out_fas_out, out_stuff_out, out_pt_out, out_tu_ts_out,
                out_trib_out, out_data_out}),
      .ready_out(out_ready_in));

   always #25 clk_sys_in = ~clk_sys_in;

   task automatic chk(input logic [63:0] got, input logic [63:0] exp);
      checks_done++;
      if (got !== exp)
      begin
         mismatches++;
         $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   task automatic load(input logic [1:0] hop, input logic [3:0] n, input logic [2:0] kind,
                       input int cnt, input logic good);
      cfg_stop_in = 1'b1;
      for (int i = 0; i < 80; i++)
      begin
         @(negedge clk_sys_in);
         cfg_stop_in = 1'b0;
         cfg_wr_in = 1'b1;
         cfg_idx_in = 7'(i);
         cfg_kind_in = (i < cnt) ? kind : 3'h0;
      end
      @(negedge clk_sys_in);
      cfg_wr_in = 1'b0;
      cfg_hop_in = hop;
      cfg_n_in = n;
      cfg_apply_in = 1'b1;
      fw_u.words_q.delete();
      @(negedge clk_sys_in);
      cfg_apply_in = 1'b0;
      repeat (84) @(negedge clk_sys_in);
      chk({cfg_ok_out, cfg_err_out}, {good, !good});
   endtask

   task automatic run(input logic v);
      logic [57:0] e;
      cli_valid_in = v;
      load(2'h0, 4'h0, CL_ODU3, 1, 1'b1);
      repeat (300)
      begin
         @(negedge clk_sys_in);
         if (cli_ready_out === 1'b1)
            chk(slot_trib_out, 7'h00);
      end
      cfg_wr_in = 1'b1;
      @(negedge clk_sys_in);
      cfg_wr_in = 1'b0;
      cfg_stop_in = 1'b1;
      chk(cfg_wr_refused_out, 1'b1);
      @(negedge clk_sys_in);
      cfg_stop_in = 1'b0;
      chk(cfg_ok_out, 1'b0);
      repeat (4) @(negedge clk_sys_in);
      chk(fw_u.words_q.size() > 20, 1'b1);
      foreach (fw_u.words_q[k])
      begin
         e[57] = (k % 31 == 0);
         e[56:0] = (k % 248 == 0) ? {2'b10, 16'h151f, 7'h00, 32'ha5a5_5a5a} :
                   v ? {2'b00, 16'h151f, 7'h00, 32'h1234_5678} : {2'b01, 16'h151f, 7'h00, 32'h0};
         chk(fw_u.words_q[k], e);
      end
      $display("test run done");
   endtask

   task automatic summarize();
      $display("checks %0d mismatches %0d", checks_done, mismatches);
      if (mismatches == 0 && checks_done > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask

   initial
   begin
      #500_000;
      mismatches++;
      summarize();
   end

   initial
   begin
      repeat (5) @(negedge clk_sys_in);
      sys_rst_in = 1'b0;
      chk({cfg_busy_out, cfg_ok_out, out_valid_out}, 3'h0);
      load(2'h0, 4'h0, CL_ODU0, 80, 1'b1);
      load(2'h0, 4'h0, CL_ODU1, 41, 1'b0);
      load(2'h0, 4'h0, CL_ODU3, 3, 1'b0);
      load(2'h0, 4'h0, CL_ODU4, 1, 1'b0);
      load(2'h1, 4'h0, CL_ODU2E, 3, 1'b0);
      load(2'h1, 4'h0, CL_FLEX, 20, 1'b1);
      load(2'h2, 4'h0, CL_ODU3, 1, 1'b1);
      load(2'h2, 4'h0, CL_ODU2, 6, 1'b0);
      load(2'h3, 4'h1, CL_ODU4, 2, 1'b0);
      load(2'h3, 4'h0, CL_ODU0, 1, 1'b0);
      load(2'h3, 4'h1, CL_ODU3, 2, 1'b1);
      $display("test limits done");
      run(1'b1);
      run(1'b0);
      summarize();
   end
endmodule
